/* hdl/sarseq_core.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Trigger loads approximation register with only bit 9 set, then compares.
// - Keep the trial bit when reference is below input, else clear it.
// - After bit 9, set bit 8, compare, keep or clear it.
// - Repeat trial-and-compare from bit 7 down to bit 0, one per step.
// - After bit 0, copy the register into the channel's result register.
// - Reference generator is driven from the current approximation register value.
// - Eight-bit mode reports the upper eight bits of the 10-bit register.
// - Input between reference and analog supply yields all-ones code.
// - When all selected channels are done, raise done flag, drop start, stop.
module sarseq_core (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_sync_reset,
  input wire logic i_trigger,
  input wire logic [sarseq_pkg::SARSEQ_CH_W-1:0] i_last_channel,
  input wire logic i_eight_bit_mode,
  input wire logic i_ref_below_input,
  output logic [sarseq_pkg::SARSEQ_BITS-1:0] o_reference_code,
  output logic o_busy,
  output logic o_start_flag,
  output logic o_done_irq,
  output logic o_result_write,
  output logic [sarseq_pkg::SARSEQ_CH_W-1:0] o_result_channel,
  output logic [sarseq_pkg::SARSEQ_BITS-1:0] o_result_data
);
  import sarseq_pkg::*;

  // ===========================================================================
  // Comparator input synchroniser
  // The comparator is analog and asynchronous, so it passes two flops first.
  logic cmp_meta;
  logic cmp_sync;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= i_ref_below_input;
      cmp_sync <= cmp_meta;
    end
  end

  // ===========================================================================
  // Sequencer
  // Each bit waits for the synchronised comparator, so a trial is three clocks:
  // set the bit, let the decision pass the synchroniser, then resolve it.
  sarseq_state_e state, next_state;
  logic [9:0] sar, next_sar;
  logic [3:0] bit_idx, next_bit_idx;
  logic [1:0] settle, next_settle;
  logic [2:0] channel, next_channel;
  logic busy, next_busy;
  logic start_flag, next_start_flag;
  logic done_irq, next_done_irq;
  logic result_write, next_result_write;
  logic [2:0] result_channel, next_result_channel;
  logic [9:0] result_data, next_result_data;

  always_comb begin
    next_state = state;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_settle = settle;
    next_channel = channel;
    next_busy = busy;
    next_start_flag = start_flag;
    next_done_irq = 1'b0;
    next_result_write = 1'b0;
    next_result_channel = result_channel;
    next_result_data = result_data;
    if (i_sync_reset) begin
      next_state = SARSEQ_IDLE;
      next_sar = SARSEQ_CLEAR;
      next_busy = 1'b0;
      next_start_flag = 1'b0;
      next_channel = SARSEQ_CH_ZERO;
    end else begin
      unique case (state)
        SARSEQ_IDLE: begin
          if (i_trigger) begin
            next_sar = SARSEQ_MSB_ONLY;
            next_bit_idx = SARSEQ_TOP_BIT;
            next_settle = 2'd0;
            next_channel = SARSEQ_CH_ZERO;
            next_busy = 1'b1;
            next_start_flag = 1'b1;
            next_state = SARSEQ_TRIAL;
          end
        end
        SARSEQ_TRIAL: begin
          if (settle != 2'd2) begin
            next_settle = settle + 2'd1;
          end else begin
            next_settle = 2'd0;
            // A high input (up to the analog supply) keeps every bit: all ones.
            next_sar[bit_idx] = cmp_sync;
            if (bit_idx == SARSEQ_BIT_ZERO) begin
              next_state = SARSEQ_STORE;
            end else begin
              next_sar[bit_idx - 4'd1] = 1'b1;
              next_bit_idx = bit_idx - 4'd1;
            end
          end
        end
        SARSEQ_STORE: begin
          next_result_write = 1'b1;
          next_result_channel = channel;
          if (i_eight_bit_mode) begin
            next_result_data = {2'b00, sar[9:2]};
          end else begin
            next_result_data = sar;
          end
          if (channel == i_last_channel) begin
            next_done_irq = 1'b1;
            next_start_flag = 1'b0;
            next_busy = 1'b0;
            next_state = SARSEQ_IDLE;
          end else begin
            next_channel = channel + 3'd1;
            next_sar = SARSEQ_MSB_ONLY;
            next_bit_idx = SARSEQ_TOP_BIT;
            next_state = SARSEQ_TRIAL;
          end
        end
        default: begin
          next_state = SARSEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SARSEQ_IDLE;
      sar <= SARSEQ_CLEAR;
      bit_idx <= SARSEQ_TOP_BIT;
      settle <= 2'd0;
      channel <= SARSEQ_CH_ZERO;
      busy <= 1'b0;
      start_flag <= 1'b0;
      done_irq <= 1'b0;
      result_write <= 1'b0;
      result_channel <= SARSEQ_CH_ZERO;
      result_data <= SARSEQ_CLEAR;
    end else begin
      state <= next_state;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      settle <= next_settle;
      channel <= next_channel;
      busy <= next_busy;
      start_flag <= next_start_flag;
      done_irq <= next_done_irq;
      result_write <= next_result_write;
      result_channel <= next_result_channel;
      result_data <= next_result_data;
    end
  end

  assign o_reference_code = sar;
  assign o_busy = busy;
  assign o_start_flag = start_flag;
  assign o_done_irq = done_irq;
  assign o_result_write = result_write;
  assign o_result_channel = result_channel;
  assign o_result_data = result_data;

  // ===========================================================================
  // Trial length monitor
  // A small count of trial cycles keeps the length check free of long repetitions.
  logic [4:0] trial_len, next_trial_len;

  always_comb begin
    next_trial_len = 5'h00;
    if (state == SARSEQ_TRIAL) begin
      next_trial_len = trial_len + 5'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trial_len <= 5'h00;
    end else begin
      trial_len <= next_trial_len;
    end
  end

  // ===========================================================================
  // Checks
  a_trigger_loads_msb: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_IDLE && i_trigger && !i_sync_reset |=> sar == SARSEQ_MSB_ONLY && busy)
    else $error("trigger did not load mid-scale");
  a_bit_decision: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_TRIAL && settle == 2'd2 && !i_sync_reset
    |=> sar[$past(bit_idx)] == $past(cmp_sync))
    else $error("bit decision does not follow comparator");
  a_next_trial_set: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_TRIAL && settle == 2'd2 && bit_idx != 4'h0 && !i_sync_reset
    |=> bit_idx == $past(bit_idx) - 4'd1 && sar[bit_idx] == 1'b1)
    else $error("next bit not trial-set");
  a_conversion_length: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_STORE |-> trial_len == SARSEQ_TRIAL_CYCLES)
    else $error("conversion length wrong");
  a_busy_span: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    busy == (state != SARSEQ_IDLE) && start_flag == busy)
    else $error("busy span wrong");
  a_store_writes: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_STORE && !i_sync_reset && !i_eight_bit_mode
    |=> result_write && result_data == $past(sar))
    else $error("result not stored");
  a_eight_bit_view: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    state == SARSEQ_STORE && !i_sync_reset && i_eight_bit_mode
    |=> result_data == {2'b00, $past(sar[9:2])})
    else $error("eight-bit result wrong");
  a_done_stops: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    done_irq |-> !start_flag && !busy && state == SARSEQ_IDLE)
    else $error("done without stop");
  a_sync_reset_idle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_sync_reset |=> state == SARSEQ_IDLE && sar == 10'h000 && !busy && !result_write)
    else $error("sync reset did not idle");
endmodule
`default_nettype wire

/* hdl/sarseq_pkg.sv */
package sarseq_pkg;
  // ===========================================================================
  // Widths and codes
  localparam int SARSEQ_BITS = 10;
  localparam int SARSEQ_CHANNELS = 8;
  localparam int SARSEQ_CH_W = 3;
  localparam logic [9:0] SARSEQ_MSB_ONLY = 10'h200;
  localparam logic [9:0] SARSEQ_CLEAR = 10'h000;
  localparam logic [9:0] SARSEQ_FULL_SCALE = 10'h3FF;
  localparam logic [3:0] SARSEQ_TOP_BIT = 4'h9;
  localparam logic [3:0] SARSEQ_BIT_ZERO = 4'h0;
  localparam logic [2:0] SARSEQ_CH_ZERO = 3'h0;
  // Ten bits at three clocks each: set, synchronise, resolve.
  localparam logic [4:0] SARSEQ_TRIAL_CYCLES = 5'h1E;

  typedef enum logic [1:0] {
    SARSEQ_IDLE = 2'b00,
    SARSEQ_TRIAL = 2'b01,
    SARSEQ_STORE = 2'b11
  } sarseq_state_e;
endpackage

/* sim/sar_adc_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the sequencer.
module sar_adc_sequencer_tb;
  import sarseq_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_sync_reset = 1'b0;
  logic i_trigger = 1'b0;
  logic [2:0] i_last_channel = 3'h0;
  logic i_eight_bit_mode = 1'b0;
  logic [11:0] level = 12'h000;
  logic cmp;
  logic [9:0] o_reference_code;
  logic o_busy, o_start_flag, o_done_irq, o_result_write;
  logic [2:0] o_result_channel;
  logic [9:0] o_result_data;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  logic [11:0] lv [8] = '{12'h000, 12'h001, 12'h002, 12'h400, 12'h401, 12'h7FF, 12'hBB8, 12'h2BC};
  logic eb [8] = '{0, 0, 0, 1, 0, 0, 0, 1};
  logic [2:0] la [8] = '{0, 0, 0, 0, 2, 7, 0, 0};
  logic [9:0] ex [8] = '{10'h000, 10'h000, 10'h001, 10'h080, 10'h200, 10'h3FF, 10'h3FF, 10'h057};
  always #2.5 i_clock = ~i_clock;
  sarseq_core i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_sync_reset(i_sync_reset),
    .i_trigger(i_trigger), .i_last_channel(i_last_channel), .i_eight_bit_mode(i_eight_bit_mode),
    .i_ref_below_input(cmp), .o_reference_code(o_reference_code), .o_busy(o_busy),
    .o_start_flag(o_start_flag), .o_done_irq(o_done_irq), .o_result_write(o_result_write),
    .o_result_channel(o_result_channel), .o_result_data(o_result_data));
  sarseq_cmp_model i_cmp (.i_reference_code(o_reference_code), .i_level(level),
    .o_ref_below_input(cmp));
  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task test_done;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task quiet(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(negedge i_clock);
      if (o_result_write === 1'b1) cnt++;
    end
  endtask
  task conv(input logic [11:0] l, input logic e, input logic [2:0] last, input logic [9:0] x);
    int w;
    level = l;
    i_eight_bit_mode = e;
    i_last_channel = last;
    i_trigger = 1'b1;
    @(negedge i_clock);
    i_trigger = 1'b0;
    chk({o_busy, o_start_flag, o_reference_code}, {2'b11, SARSEQ_MSB_ONLY}, "start");
    for (int ch = 0; ch <= last; ch++) begin
      w = 0;
      do begin
        @(negedge i_clock);
        w++;
      end while (o_result_write !== 1'b1 && w < 40);
      chk({o_busy, o_done_irq, o_result_channel, o_result_data},
        {ch != last, ch == last, ch[2:0], x}, "result");
    end
  endtask
  initial begin
    #25000;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    test_done;
  end
  initial begin
    repeat (3) @(negedge i_clock);
    chk({o_busy, o_reference_code, o_result_write}, 16'h0000, "reset");
    i_rst_n = 1'b1;
    // Rows run back to back: each trigger lands in the done cycle of the one before.
    for (int i = 0; i < 8; i++) conv(lv[i], eb[i], la[i], ex[i]);
    $display("Test done: table");
    i_trigger = 1'b1;
    @(negedge i_clock);
    i_trigger = 1'b0;
    repeat (10) @(negedge i_clock);
    i_sync_reset = 1'b1;
    @(negedge i_clock);
    i_sync_reset = 1'b0;
    chk({o_busy, o_start_flag, o_reference_code}, 16'h0000, "sync reset");
    quiet(40, n);
    chk(n, 0, "write after sync reset");
    $display("Test done: sync reset");
    i_trigger = 1'b1;
    @(negedge i_clock);
    i_trigger = 1'b0;
    repeat (5) @(negedge i_clock);
    i_trigger = 1'b1;
    @(negedge i_clock);
    i_trigger = 1'b0;
    // Bit 9 cleared and bit 8 kept for this level; a restart would show mid-scale.
    chk(o_reference_code, 10'h180, "trigger while busy restarted");
    quiet(60, n);
    chk(n, 1, "trigger while busy");
    $display("Test done: busy trigger");
    test_done;
  end
endmodule
`default_nettype wire

/* sim/sarseq_cmp_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Comparator and reference generator model.
module sarseq_cmp_model (
  input wire logic [9:0] i_reference_code,
  input wire logic [11:0] i_level,
  output logic o_ref_below_input
);
  logic [11:0] ref_level;
  // Levels count half codes, so a level past 12'h800 stands for the supply rail.
  assign ref_level = (i_reference_code == 10'h000) ? 12'h000 :
    {1'b0, i_reference_code, 1'b0} - 12'h001;
  // Equal levels read as not below, the harsher case for the sequencer.
  assign o_ref_below_input = ref_level < i_level;
endmodule
`default_nettype wire
